// *** cgd_clock_gen.sv ***
// clock generation and distribution top: sources, pll, timewheels, dividers
// Functional notes
// - doubler gives twice input frequency, 24 to 48
// - doubler input: main osc, fast crystal, interconnect
// - pll 24-67 MHz, 4032 divider ratios
// - pll reference selectable, locks within 250 us
// - lock bit set; software waits for it
// - lock indication routable to interconnect for interrupt
// - low speed path gives 1k, 33k, 100k
// - central timewheel: free 13-bit counter on 1k
// - timewheel halts in hibernate and debug halt
// - firmware can clear central timewheel
// - periodic wake events, optional interrupt each
// - fast timewheel: 5-bit, terminal count, auto zero
// - fast timewheel interrupt at each terminal count
// - 33k clock is 100k divided by three
// - watch crystal gives one-second interrupt
// - eight dedicated interconnect clocks, one per digital divider; analog dividers 0-3 reuse dedicated clocks 0-3
// - all seven sources selectable, system clock chosen
// - bus clock divided from system; cpu equals bus
// - eight digital, four analog dividers; analog skew
// - 8-input mux, 16-bit divide, resync, deglitch
// - digital outputs routable out for 32-bit chaining
// - central timewheel stays wake source in sleep
`timescale 1ns/1ps
module cgd_clock_gen
  import cgd_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES,
  parameter int WATCH_COUNT = WATCH_HZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // oscillator and interconnect clock levels
  input wire logic i_internal_main_osc,
  input wire logic i_fast_crystal_osc,
  input wire logic i_interconnect_clk,
  input wire logic i_slow_clock_1k,
  input wire logic i_slow_clock_100k,
  input wire logic i_watch_crystal_osc,
  input wire logic [NUM_DIG-1:0] i_dedicated_clk,
  // power state
  input wire logic i_sleep,
  input wire logic i_hibernate,
  input wire logic i_debug_halt,
  // doubler and pll control
  input wire logic [1:0] i_doubler_ref_sel,
  input wire logic i_pll_en,
  input wire logic [1:0] i_pll_ref_sel,
  input wire logic [PLL_IN_W-1:0] i_pll_in_div,
  input wire logic [PLL_FB_W-1:0] i_pll_fb_div,
  // timewheel control
  input wire logic i_ctw_clear,
  input wire logic i_ctw_wake_en,
  input wire logic i_ctw_irq_en,
  input wire logic [CTW_SEL_W-1:0] i_ctw_wake_sel,
  input wire logic i_ftw_en,
  input wire logic i_ftw_irq_en,
  input wire logic [FTW_W-1:0] i_ftw_terminal,
  // distribution control
  input wire logic [SEL_W-1:0] i_sys_sel,
  input wire logic [DIV_W-1:0] i_bus_div,
  input wire logic [NUM_DIG-1:0][SEL_W-1:0] i_dig_sel,
  input wire logic [NUM_DIG-1:0][DIV_W-1:0] i_dig_div,
  input wire logic [NUM_ANA-1:0][SEL_W-1:0] i_ana_sel,
  input wire logic [NUM_ANA-1:0][DIV_W-1:0] i_ana_div,
  input wire logic [NUM_ANA-1:0][SKEW_W-1:0] i_ana_skew,
  // generated clocks and strobes
  output logic o_usb_clk_strobe,
  output logic o_pll_clk_strobe,
  output logic o_pll_locked,
  output logic o_pll_lock_route,
  output logic o_slow_clock_1k,
  output logic o_slow_clock_33k,
  output logic o_slow_clock_100k,
  output logic o_sys_clk_strobe,
  output logic o_bus_clk,
  output logic o_cpu_clk,
  output logic [NUM_DIG-1:0] o_dig_clk,
  output logic [NUM_ANA-1:0] o_ana_clk,
  // timewheels and real time
  output logic [CTW_W-1:0] o_ctw_count,
  output logic o_ctw_wake,
  output logic o_ctw_irq,
  output logic [FTW_W-1:0] o_ftw_count,
  output logic o_ftw_irq,
  output logic o_rtc_second
);
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int WW = $clog2(WATCH_COUNT + 1);

  // *****************************
  // edge detection of source levels
  // *****************************
  logic [5:0] lvl_prev_reg;
  logic [NUM_DIG-1:0] ded_prev_reg;
  logic [5:0] lvl_now;
  logic [5:0] rise;
  logic [NUM_DIG-1:0] ded_rise;

  assign lvl_now = {i_watch_crystal_osc, i_slow_clock_100k, i_slow_clock_1k,
                    i_interconnect_clk, i_fast_crystal_osc, i_internal_main_osc};
  assign rise = lvl_now & ~lvl_prev_reg;
  assign ded_rise = i_dedicated_clk & ~ded_prev_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_prev_reg <= 6'h00;
      ded_prev_reg <= '0;
    end else begin
      lvl_prev_reg <= lvl_now;
      ded_prev_reg <= i_dedicated_clk;
    end
  end

  // *****************************
  // clock doubler
  // *****************************
  logic dbl_lvl;
  logic dbl_prev;
  always_comb begin
    unique case (i_doubler_ref_sel)
      REF_FAST_XTAL: dbl_lvl = lvl_now[1];
      REF_INTERCONNECT: dbl_lvl = lvl_now[2];
      default: dbl_lvl = lvl_now[0];
    endcase
  end
  always_comb begin
    unique case (i_doubler_ref_sel)
      REF_FAST_XTAL: dbl_prev = lvl_prev_reg[1];
      REF_INTERCONNECT: dbl_prev = lvl_prev_reg[2];
      default: dbl_prev = lvl_prev_reg[0];
    endcase
  end

  // both input edges give one strobe each: two per input period
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_usb_clk_strobe <= 1'b0;
    end else begin
      o_usb_clk_strobe <= dbl_lvl ^ dbl_prev;
    end
  end

  // *****************************
  // pll: lock timer and rate multiplier
  // *****************************
  logic [LOCK_W-1:0] lock_cnt_reg;
  logic locked_prev_reg;
  logic [PLL_CRED_W-1:0] cred_reg;
  logic ref_rise;
  logic [PLL_FB_W-1:0] fb_eff;
  logic [PLL_IN_W:0] in_eff;
  logic emit;
  logic [PLL_CRED_W:0] cred_sum;

  always_comb begin
    unique case (i_pll_ref_sel)
      REF_FAST_XTAL: ref_rise = rise[1];
      REF_INTERCONNECT: ref_rise = rise[2];
      default: ref_rise = rise[0];
    endcase
  end

  // 16 input by 252 feedback settings
  assign fb_eff = (i_pll_fb_div < PLL_FB_MIN) ? PLL_FB_MIN : i_pll_fb_div;
  assign in_eff = {1'b0, i_pll_in_div} + (PLL_IN_W + 1)'(1);
  assign emit = o_pll_locked && (cred_reg >= PLL_CRED_W'(in_eff));
  assign cred_sum = {1'b0, cred_reg} + (ref_rise ? (PLL_CRED_W + 1)'(fb_eff) : '0)
                    - (emit ? (PLL_CRED_W + 1)'(in_eff) : '0);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_cnt_reg <= '0;
      o_pll_locked <= 1'b0;
    end else if (!i_pll_en) begin
      lock_cnt_reg <= '0;
      o_pll_locked <= 1'b0;
    end else if (lock_cnt_reg == LOCK_W'(LOCK_CYCLES - 1)) begin
      o_pll_locked <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + LOCK_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      locked_prev_reg <= 1'b0;
      o_pll_lock_route <= 1'b0;
    end else begin
      locked_prev_reg <= o_pll_locked;
      o_pll_lock_route <= o_pll_locked & ~locked_prev_reg;
    end
  end

  // saturation keeps a fast reference from wrapping the credit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cred_reg <= '0;
      o_pll_clk_strobe <= 1'b0;
    end else if (!o_pll_locked) begin
      cred_reg <= '0;
      o_pll_clk_strobe <= 1'b0;
    end else begin
      cred_reg <= cred_sum[PLL_CRED_W] ? '1 : cred_sum[PLL_CRED_W-1:0];
      o_pll_clk_strobe <= emit;
    end
  end

  // *****************************
  // low speed clocks
  // *****************************
  logic [1:0] div3_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div3_reg <= 2'h0;
      o_slow_clock_33k <= 1'b0;
      o_slow_clock_1k <= 1'b0;
      o_slow_clock_100k <= 1'b0;
    end else begin
      o_slow_clock_1k <= i_slow_clock_1k;
      o_slow_clock_100k <= i_slow_clock_100k;
      if (rise[4]) begin
        div3_reg <= (div3_reg == SLOW_DIV3_LAST) ? 2'h0 : div3_reg + 2'h1;
        o_slow_clock_33k <= (div3_reg == SLOW_DIV3_LAST);
      end
    end
  end

  // *****************************
  // central timewheel
  // *****************************
  logic ctw_tick;
  logic [CTW_W-1:0] wake_mask;
  logic ctw_hit;
  // sleep does not stop it, only hibernate and debug halt
  assign ctw_tick = rise[3] && !i_hibernate && !i_debug_halt;
  assign wake_mask = ~({CTW_W{1'b1}} << i_ctw_wake_sel);
  assign ctw_hit = ctw_tick && ((o_ctw_count & wake_mask) == wake_mask);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctw_count <= '0;
    end else if (i_ctw_clear) begin
      o_ctw_count <= '0;
    end else if (ctw_tick) begin
      o_ctw_count <= o_ctw_count + CTW_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctw_wake <= 1'b0;
      o_ctw_irq <= 1'b0;
    end else begin
      o_ctw_wake <= ctw_hit && i_ctw_wake_en && !i_ctw_clear;
      o_ctw_irq <= ctw_hit && i_ctw_wake_en && i_ctw_irq_en && !i_ctw_clear;
    end
  end

  // *****************************
  // fast timewheel
  // *****************************
  logic ftw_tc;
  assign ftw_tc = (o_ftw_count == i_ftw_terminal);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ftw_count <= '0;
      o_ftw_irq <= 1'b0;
    end else begin
      o_ftw_irq <= 1'b0;
      if (!i_ftw_en) begin
        o_ftw_count <= '0;
      end else if (rise[4]) begin
        o_ftw_count <= ftw_tc ? '0 : o_ftw_count + FTW_W'(1);
        o_ftw_irq <= ftw_tc && i_ftw_irq_en;
      end
    end
  end

  // *****************************
  // watch crystal seconds
  // *****************************
  logic [WW-1:0] sec_cnt_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sec_cnt_reg <= '0;
      o_rtc_second <= 1'b0;
    end else begin
      o_rtc_second <= 1'b0;
      if (rise[5]) begin
        if (sec_cnt_reg == WW'(WATCH_COUNT - 1)) begin
          sec_cnt_reg <= '0;
          o_rtc_second <= 1'b1;
        end else begin
          sec_cnt_reg <= sec_cnt_reg + WW'(1);
        end
      end
    end
  end

  // *****************************
  // system clock and divider bank
  // *****************************
  logic [NUM_SRC-2:0] gen_src;
  logic sys_strobe;
  assign gen_src = {rise[5], rise[4], o_usb_clk_strobe, o_pll_clk_strobe, rise[2], rise[1], rise[0]};
  // code seven has no source and falls back to the main oscillator
  assign sys_strobe = (i_sys_sel == SRC_DEDICATED) ? gen_src[SRC_MAIN_OSC] : gen_src[i_sys_sel];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sys_clk_strobe <= 1'b0;
    end else begin
      o_sys_clk_strobe <= sys_strobe;
    end
  end

  cgd_div_if #(.DIV_W(DIV_W), .SKEW_W(SKEW_W)) dig_if [NUM_DIG] ();
  cgd_div_if #(.DIV_W(DIV_W), .SKEW_W(SKEW_W)) ana_if [NUM_ANA] ();
  cgd_div_if #(.DIV_W(DIV_W), .SKEW_W(SKEW_W)) bus_if ();

  genvar g;
  generate
    for (g = 0; g < NUM_DIG; g++) begin : g_dig
      assign dig_if[g].src = {ded_rise[g], gen_src};
      assign dig_if[g].sel = i_dig_sel[g];
      assign dig_if[g].div = i_dig_div[g];
      assign dig_if[g].skew = '0;
      // leaves as a port so the interconnect can feed it back in
      assign o_dig_clk[g] = dig_if[g].clk_out;
      cgd_divider u_div (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(dig_if[g]));
    end
    for (g = 0; g < NUM_ANA; g++) begin : g_ana
      assign ana_if[g].src = {ded_rise[g], gen_src};
      assign ana_if[g].sel = i_ana_sel[g];
      assign ana_if[g].div = i_ana_div[g];
      assign ana_if[g].skew = i_ana_skew[g];
      assign o_ana_clk[g] = ana_if[g].clk_out;
      cgd_divider u_div (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(ana_if[g]));
    end
  endgenerate

  assign bus_if.src = {NUM_SRC{o_sys_clk_strobe}};
  assign bus_if.sel = SRC_MAIN_OSC;
  assign bus_if.div = i_bus_div;
  assign bus_if.skew = '0;
  cgd_divider u_bus_div (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus_if));

  assign o_bus_clk = bus_if.clk_out;
  assign o_cpu_clk = bus_if.clk_out;
endmodule // cgd_clock_gen

// *** cgd_pkg.sv ***
// constants shared by the clock generation and distribution block
package cgd_pkg;
  localparam int SYS_CLK_MHZ = 200;
  localparam int PLL_LOCK_US = 250;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * SYS_CLK_MHZ;
  localparam int NUM_SRC = 8;
  localparam int SEL_W = 3;
  localparam int DIV_W = 16;
  localparam int SKEW_W = 2;
  localparam int NUM_DIG = 8;
  localparam int NUM_ANA = 4;
  localparam int CTW_W = 13;
  localparam int CTW_SEL_W = 4;
  localparam int FTW_W = 5;
  localparam int PLL_IN_W = 4;
  localparam int PLL_FB_W = 8;
  localparam int PLL_CRED_W = 10;
  localparam logic [PLL_FB_W-1:0] PLL_FB_MIN = 8'h04;
  localparam int WATCH_HZ = 32768;
  localparam int WATCH_W = 15;
  localparam logic [1:0] SLOW_DIV3_LAST = 2'h2;
  localparam logic [DIV_W-1:0] DIV_MIN = 16'h0002;
  localparam logic [SEL_W-1:0] SRC_MAIN_OSC = 3'h0;
  localparam logic [SEL_W-1:0] SRC_FAST_XTAL = 3'h1;
  localparam logic [SEL_W-1:0] SRC_INTERCONNECT = 3'h2;
  localparam logic [SEL_W-1:0] SRC_PLL = 3'h3;
  localparam logic [SEL_W-1:0] SRC_DOUBLER = 3'h4;
  localparam logic [SEL_W-1:0] SRC_LOW_SPEED = 3'h5;
  localparam logic [SEL_W-1:0] SRC_WATCH_XTAL = 3'h6;
  localparam logic [SEL_W-1:0] SRC_DEDICATED = 3'h7;
  localparam logic [1:0] REF_MAIN_OSC = 2'h0;
  localparam logic [1:0] REF_FAST_XTAL = 2'h1;
  localparam logic [1:0] REF_INTERCONNECT = 2'h2;
endpackage

// *** cgd_div_if.sv ***
// signals between the top and one clock divider
`timescale 1ns/1ps
interface cgd_div_if #(
  parameter int DIV_W = 16,
  parameter int SKEW_W = 2
);
  logic [7:0] src;
  logic [2:0] sel;
  logic [DIV_W-1:0] div;
  logic [SKEW_W-1:0] skew;
  logic clk_out;
  modport ctrl (output src, output sel, output div, output skew, input clk_out);
  modport div_end (input src, input sel, input div, input skew, output clk_out);
endinterface

// *** cgd_divider.sv ***
// one 16-bit clock divider with source mux, boundary reload and skew delay
`timescale 1ns/1ps
module cgd_divider
  import cgd_pkg::*;
#(
  parameter int DW = DIV_W,
  parameter int SW = SKEW_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control and output
  cgd_div_if.div_end bus
);
  localparam int TAPS = (1 << SW) - 1;
  localparam logic [DW-1:0] DMIN = DW'(DIV_MIN);

  logic [2:0] sel_reg;
  logic [DW-1:0] n_reg;
  logic [DW-1:0] cnt_reg;
  logic lvl_reg;
  logic [TAPS-1:0] sh_reg;
  logic out_reg;
  logic src_edge;
  logic [DW-1:0] n_next;

  assign src_edge = bus.src[sel_reg];
  // values below two are raised to two
  assign n_next = (bus.div < DMIN) ? DMIN : bus.div;

  // *****************************
  // count, reload only at boundary
  // *****************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_reg <= 3'h0;
      n_reg <= DMIN;
      cnt_reg <= '0;
    end else if (src_edge) begin
      if (cnt_reg == n_reg - DW'(1)) begin
        cnt_reg <= '0;
        sel_reg <= bus.sel;
        n_reg <= n_next;
      end else begin
        cnt_reg <= cnt_reg + DW'(1);
      end
    end
  end

  // *****************************
  // resync, skew, deglitched output
  // *****************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_reg <= 1'b0;
      sh_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      lvl_reg <= (cnt_reg < (n_reg >> 1));
      sh_reg <= TAPS'({sh_reg, lvl_reg});
      // a registered tap keeps mux switching off the clock consumers
      out_reg <= (bus.skew == '0) ? lvl_reg : sh_reg[bus.skew - SW'(1)];
    end
  end

  assign bus.clk_out = out_reg;
endmodule // cgd_divider

// *** cgd_sva.sv ***
// assertions on the ports of the clock generation top
`timescale 1ns/1ps
module cgd_sva
  import cgd_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  // clock, reset and controls
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_pll_en,
  input wire logic i_hibernate,
  input wire logic i_debug_halt,
  input wire logic i_ctw_clear,
  input wire logic i_ctw_wake_en,
  input wire logic i_ctw_irq_en,
  // watched outputs
  input wire logic o_pll_locked,
  input wire logic o_pll_lock_route,
  input wire logic o_pll_clk_strobe,
  input wire logic o_bus_clk,
  input wire logic o_cpu_clk,
  input wire logic [CTW_W-1:0] o_ctw_count,
  input wire logic o_ctw_wake,
  input wire logic o_ctw_irq,
  input wire logic [FTW_W-1:0] o_ftw_count,
  input wire logic o_ftw_irq,
  input wire logic o_rtc_second
);
  int en_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ****************************************
  // unbroken enable run, saturating
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_cnt <= 0;
    end else begin
      en_cnt <= !i_pll_en ? 0 : (en_cnt > LOCK_CYCLES ? en_cnt : en_cnt + 1);
    end
  end
  a_lock_delay: assert property ($rose(o_pll_locked) |-> en_cnt == LOCK_CYCLES)
    else $error("lock rose after wrong delay");
  a_route_pulse: assert property ($rose(o_pll_locked) |=> o_pll_lock_route ##1 !o_pll_lock_route)
    else $error("lock route pulse missing");
  a_unlock_drop: assert property (!i_pll_en |=> !o_pll_locked)
    else $error("lock held after disable");
  a_strobe_gate: assert property (!o_pll_locked && !$past(o_pll_locked) |-> !o_pll_clk_strobe)
    else $error("pll strobe while unlocked");
  a_bus_cpu: assert property (o_cpu_clk == o_bus_clk)
    else $error("cpu clock differs from bus clock");
  a_ctw_clear: assert property (i_ctw_clear |=> o_ctw_count == '0 && !o_ctw_wake && !o_ctw_irq)
    else $error("timewheel not cleared");
  a_ctw_halt: assert property ((i_hibernate || i_debug_halt) && !i_ctw_clear |=> $stable(o_ctw_count))
    else $error("timewheel moved while halted");
  a_ctw_step: assert property ($changed(o_ctw_count) && !$past(i_ctw_clear)
    |-> o_ctw_count == CTW_W'($past(o_ctw_count) + 1'b1))
    else $error("timewheel step not one");
  a_ctw_irq_gate: assert property (o_ctw_irq |-> $past(i_ctw_irq_en) && $past(i_ctw_wake_en))
    else $error("timewheel irq while disabled");
  a_ftw_wrap: assert property (o_ftw_irq |-> o_ftw_count == '0)
    else $error("fast timewheel irq without wrap");
  a_sec_single: assert property (o_rtc_second |=> !o_rtc_second)
    else $error("seconds pulse too long");
endmodule // cgd_sva

// *** cgd_osc_model.sv ***
// free running oscillator levels that feed the clock block
`timescale 1ns/1ps
module cgd_osc_model (
  // clock
  input wire logic i_clk,
  // oscillator levels
  output logic o_main,
  output logic o_fast,
  output logic o_ic,
  output logic o_k100,
  output logic o_k1,
  output logic o_watch,
  output logic [7:0] o_ded
);
  logic [7:0] cnt_reg = 8'h00;
  // moves on the falling edge so no level changes at a sampling edge
  always @(negedge i_clk) cnt_reg <= cnt_reg + 8'h01;
  assign o_watch = cnt_reg[0];
  assign o_main = cnt_reg[1];
  assign o_fast = cnt_reg[2];
  assign o_ic = cnt_reg[3];
  assign o_k100 = cnt_reg[4];
  assign o_k1 = cnt_reg[7];
  assign o_ded = {cnt_reg[4:1], cnt_reg[4:1]};
endmodule // cgd_osc_model

// *** tb.sv ***
// self-checking bench for the clock generation top
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import cgd_pkg::*;
  localparam int LOCK = 20;
  logic i_clk = 1'b0, i_arst_n = 1'b0;
  logic i_sleep, i_hibernate, i_debug_halt, i_pll_en, i_ctw_clear, i_ctw_wake_en, i_ctw_irq_en, i_ftw_en, i_ftw_irq_en;
  logic [1:0] i_doubler_ref_sel, i_pll_ref_sel;
  logic [3:0] i_pll_in_div, i_ctw_wake_sel;
  logic [7:0] i_pll_fb_div;
  logic [4:0] i_ftw_terminal;
  logic [2:0] i_sys_sel;
  logic [15:0] i_bus_div, n;
  logic [NUM_DIG-1:0][SEL_W-1:0] i_dig_sel;
  logic [NUM_DIG-1:0][DIV_W-1:0] i_dig_div;
  logic [NUM_ANA-1:0][SEL_W-1:0] i_ana_sel;
  logic [NUM_ANA-1:0][DIV_W-1:0] i_ana_div;
  logic [NUM_ANA-1:0][SKEW_W-1:0] i_ana_skew;
  logic main, fast, ic, k100, k1, watch, cur, prev;
  logic [7:0] ded;
  logic o_usb_clk_strobe, o_pll_clk_strobe, o_pll_locked, o_pll_lock_route, o_slow_clock_1k, o_slow_clock_33k;
  logic o_slow_clock_100k, o_sys_clk_strobe, o_bus_clk, o_cpu_clk, o_ctw_wake, o_ctw_irq, o_ftw_irq, o_rtc_second;
  logic [NUM_DIG-1:0] o_dig_clk;
  logic [NUM_ANA-1:0] o_ana_clk;
  logic [CTW_W-1:0] o_ctw_count;
  logic [FTW_W-1:0] o_ftw_count;
  logic [4:0] mode = 5'h00;
  logic [15:0] wv, e;
  logic [15:0] exp_q[$];
  int bad_count = 0, cmp_count = 0, hits = 0, ticks = 0, win_len = 1, seed = 92245;
  always #2.5 i_clk = ~i_clk;
  assign wv = {o_slow_clock_100k, o_slow_clock_1k, o_pll_lock_route, o_rtc_second, o_ctw_irq, o_ctw_wake,
    o_ftw_irq, o_slow_clock_33k,
    o_ana_clk[0], o_dig_clk[7], o_dig_clk[0], o_cpu_clk, !o_pll_locked, o_pll_clk_strobe, o_usb_clk_strobe,
    o_sys_clk_strobe};
  cgd_osc_model cgd_osc_model_i (.i_clk(i_clk), .o_main(main), .o_fast(fast), .o_ic(ic), .o_k100(k100),
    .o_k1(k1), .o_watch(watch), .o_ded(ded));
  cgd_clock_gen #(.LOCK_CYCLES(LOCK), .WATCH_COUNT(8)) cgd_clock_gen_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_internal_main_osc(main), .i_fast_crystal_osc(fast), .i_interconnect_clk(ic), .i_slow_clock_1k(k1),
    .i_slow_clock_100k(k100), .i_watch_crystal_osc(watch), .i_dedicated_clk(ded), .i_sleep(i_sleep),
    .i_hibernate(i_hibernate), .i_debug_halt(i_debug_halt), .i_doubler_ref_sel(i_doubler_ref_sel),
    .i_pll_en(i_pll_en), .i_pll_ref_sel(i_pll_ref_sel), .i_pll_in_div(i_pll_in_div), .i_pll_fb_div(i_pll_fb_div),
    .i_ctw_clear(i_ctw_clear), .i_ctw_wake_en(i_ctw_wake_en), .i_ctw_irq_en(i_ctw_irq_en),
    .i_ctw_wake_sel(i_ctw_wake_sel), .i_ftw_en(i_ftw_en), .i_ftw_irq_en(i_ftw_irq_en),
    .i_ftw_terminal(i_ftw_terminal), .i_sys_sel(i_sys_sel), .i_bus_div(i_bus_div), .i_dig_sel(i_dig_sel),
    .i_dig_div(i_dig_div), .i_ana_sel(i_ana_sel), .i_ana_div(i_ana_div), .i_ana_skew(i_ana_skew),
    .o_usb_clk_strobe(o_usb_clk_strobe), .o_pll_clk_strobe(o_pll_clk_strobe), .o_pll_locked(o_pll_locked),
    .o_pll_lock_route(o_pll_lock_route), .o_slow_clock_1k(o_slow_clock_1k), .o_slow_clock_33k(o_slow_clock_33k),
    .o_slow_clock_100k(o_slow_clock_100k), .o_sys_clk_strobe(o_sys_clk_strobe), .o_bus_clk(o_bus_clk),
    .o_cpu_clk(o_cpu_clk), .o_dig_clk(o_dig_clk), .o_ana_clk(o_ana_clk), .o_ctw_count(o_ctw_count),
    .o_ctw_wake(o_ctw_wake), .o_ctw_irq(o_ctw_irq), .o_ftw_count(o_ftw_count), .o_ftw_irq(o_ftw_irq),
    .o_rtc_second(o_rtc_second));
  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rst();
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_arst_n = 1'b1;
  endtask
  // count highs (or rises when m[4]) of one output over len cycles
  task automatic meas(input logic [4:0] m, input logic [15:0] ex, input int len, input int settle);
    // mode moves before the settle so a rise count never pairs two different outputs
    mode = m;
    win_len = len;
    repeat (settle) @(negedge i_clk);
    @(posedge i_clk);
    exp_q.push_back(ex);
    for (int k = 0; k < len + 8 && exp_q.size() > 0; k++) @(negedge i_clk);
  endtask
  // ****************************************
  // result monitor
  // ****************************************
  // outputs launch on the rising edge, so look half a period later
  always @(negedge i_clk) begin
    cur = wv[mode[3:0]];
    if (exp_q.size() > 0) begin
      hits = hits + ((mode[4] ? cur && !prev : cur) ? 1 : 0);
      ticks++;
      if (ticks == win_len) begin
        e = exp_q.pop_front();
        `CHK(16'(hits), e)
        hits = 0;
        ticks = 0;
      end
    end
    prev = cur;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    bad_count++;
    test_done();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {i_sleep, i_hibernate, i_debug_halt, i_ctw_clear, i_ctw_wake_en, i_ctw_irq_en, i_ftw_en, i_ftw_irq_en} = '0;
    {i_doubler_ref_sel, i_pll_ref_sel, i_sys_sel, i_ftw_terminal, i_dig_sel, i_ana_sel, i_ana_skew} = '0;
    // small start values: a new setting waits for the old period to end
    for (int g = 0; g < NUM_DIG; g++) i_dig_div[g] = 16'({$random(seed)} % 16);
    for (int g = 0; g < NUM_ANA; g++) i_ana_div[g] = 16'({$random(seed)} % 16);
    {i_pll_en, i_pll_in_div, i_pll_fb_div, i_ctw_wake_sel, i_bus_div} = {1'b1, 4'h1, 8'h06, 4'h1, 16'h0002};
    rst();
    // lock lands on the edge numbered LOCK; samples follow edges one onward
    meas(5'd3, 16'(LOCK - 1), 1024, 0);
    for (int r = 0; r < 3; r++) begin
      i_pll_ref_sel = 2'(r);
      meas(5'd2, 16'(768 >> r), 1024, 64);
    end
    i_pll_ref_sel = REF_MAIN_OSC;
    for (int d = 0; d < 4; d++) begin
      i_doubler_ref_sel = 2'(d);
      meas(5'd1, d == 3 ? 16'd512 : 16'(512 >> d), 1024, 64);
    end
    for (int s = 0; s < 8; s++) begin
      i_sys_sel = 3'(s);
      meas(5'd0, s == 3 ? 16'd768 : s == 4 || s == 6 ? 16'd512 : s == 5 ? 16'd32 : s == 7 ? 16'd256
        : 16'(256 >> s), 1024, 64);
    end
    i_sys_sel = SRC_MAIN_OSC;
    n = 16'h0002 + 16'({$random(seed)} % 16);
    i_bus_div = n;
    meas(5'd20, 16, 64 * n, 96);
    i_dig_div[0] = n + 16'h0001;
    meas(5'd21, 16, 64 * (n + 1), 96);
    meas(5'd5, 16'(64 * ((n + 1) / 2)), 64 * (n + 1), 0);
    {i_dig_sel[7], i_dig_div[7]} = {SRC_DEDICATED, DIV_MIN};
    meas(5'd22, 16, 1024, 96);
    {i_ana_sel[0], i_ana_div[0], i_ana_skew[0]} = {SRC_DEDICATED, n, 2'($random(seed))};
    meas(5'd23, 16, 64 * n, 96);
    meas(5'd24, 10, 960, 1);
    meas(5'd12, 64, 1024, 0);
    meas(5'd31, 32, 1024, 1);
    meas(5'd30, 8, 2048, 1);
    {i_ftw_en, i_ftw_irq_en, i_ftw_terminal} = {2'b11, 5'($random(seed))};
    meas(5'd9, 4, 128 * (int'(i_ftw_terminal) + 1), 64);
    {i_ctw_wake_en, i_ctw_irq_en} = 2'b11;
    meas(5'd10, 4, 2048, 64);
    meas(5'd11, 4, 2048, 0);
    i_ctw_irq_en = 1'b0;
    meas(5'd11, 0, 2048, 0);
    i_hibernate = 1'b1;
    meas(5'd10, 0, 2048, 0);
    {i_hibernate, i_debug_halt} = 2'b01;
    meas(5'd10, 0, 2048, 0);
    {i_debug_halt, i_ctw_clear} = 2'b01;
    meas(5'd10, 0, 2048, 0);
    i_ctw_clear = 1'b0;
    i_pll_en = 1'b0;
    i_sleep = 1'b1;
    meas(5'd10, 4, 2048, 64);
    {i_sleep, i_pll_en} = 2'b01;
    rst();
    meas(5'd3, 16'(LOCK - 1), 1024, 0);
    i_pll_en = 1'b0;
    @(negedge i_clk);
    i_pll_en = 1'b1;
    meas(5'd13, 1, 1024, 0);
    test_done();
  end
endmodule // tb
bind cgd_clock_gen cgd_sva #(.LOCK_CYCLES(LOCK_CYCLES)) cgd_sva_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_pll_en(i_pll_en), .i_hibernate(i_hibernate), .i_debug_halt(i_debug_halt), .i_ctw_clear(i_ctw_clear),
  .i_ctw_wake_en(i_ctw_wake_en), .i_ctw_irq_en(i_ctw_irq_en), .o_pll_locked(o_pll_locked),
  .o_pll_lock_route(o_pll_lock_route), .o_pll_clk_strobe(o_pll_clk_strobe), .o_bus_clk(o_bus_clk),
  .o_cpu_clk(o_cpu_clk), .o_ctw_count(o_ctw_count), .o_ctw_wake(o_ctw_wake), .o_ctw_irq(o_ctw_irq),
  .o_ftw_count(o_ftw_count), .o_ftw_irq(o_ftw_irq), .o_rtc_second(o_rtc_second));
